// file: rtl/lhcd_decoder.sv
// host bus command decoder with display ram and panel scan
`timescale 1ns/1ps
// Contract
// - register select plus strobes classify command, status, data write, data read
// - 80-style bus: low pulses on read or write strobe start cycles
// - 68-style bus: direction high reads, low writes, enable high pulse starts
// - serial bytes arrive most significant bit first
// - on/off command bit 0 switches display on or off
// - display off holds all column and row drivers at upper level
// - start-line command 01xxxxxx loads first shown line 0 to 63
// - 65 consecutive lines shown upward from the start line
// - page command 1011xxxx loads host page, valid 0 to 8
// - host page changes never alter what is shown
// - column set in two bytes, high nibble 0001, low nibble 0000
// - every host ram access below column 255 advances the column by one
// - column saturates at 255; page never advances from it
// - status: busy, direction, off, reset in bits 7..4, zeros below
// - direction status reads 1 for normal column mapping
// - display status bit reads 0 on, 1 off
// - reset status bit 1 while initialisation runs
// - data write stores byte at page and column, then advances
// - data read latches byte at page and column for the next read, then advances
// - first read after address set returns stale data
// - serial port supports writes only
// - init pin turns display off, clears start, column and page
module lhcd_decoder import lhcd_pkg::*; #(
  parameter int RESET_CYCLES = RESET_CYC
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic EXTERNAL_INIT_PIN_N,
  // port selection
  input wire logic SERIAL_SEL,
  input wire logic BUS68_SEL,
  // parallel host bus
  input wire logic REGISTER_SELECT,
  input wire logic RD_N_E,
  input wire logic WR_N_RW,
  input wire logic [7:0] DB_IN,
  output logic [7:0] DB_OUT,
  output logic DB_OE,
  // serial host port
  input wire logic SER_CS_N,
  input wire logic SER_CLK,
  input wire logic SER_DATA,
  // panel drive
  output logic DISPLAY_ON,
  output logic COLUMN_DRIVER_OUTPUT,
  output logic [NUM_LINES-1:0] ROW_DRIVER_OUTPUT,
  output logic [7:0] SCAN_COLUMN
);
  lhcd_state_type state_q;
  logic [15:0] cnt_q;
  logic rd_q, wr_q, sclk_q;
  logic [6:0] ser_sh_q;
  logic [2:0] ser_cnt_q;
  logic disp_on_q;
  logic [5:0] start_q;
  logic [3:0] page_q;
  logic [7:0] col_q, col_d;
  logic [7:0] rd_latch_q, dout_q;
  logic [7:0] ram_q [0:RAM_WORDS-1];
  logic [7:0] scan_col_q, scan_col_out_q;
  logic [6:0] scan_cnt_q;
  logic col_drv_q;
  logic [NUM_LINES-1:0] row_drv_q;

  // strobe edges; inputs are already synchronous
  wire mode80 = !SERIAL_SEL && !BUS68_SEL;
  wire mode68 = !SERIAL_SEL && BUS68_SEL;
  wire rd80 = mode80 && !rd_q && RD_N_E;
  wire wr80 = mode80 && !wr_q && WR_N_RW;
  wire e_fall = mode68 && rd_q && !RD_N_E;
  wire rd68 = e_fall && WR_N_RW;
  wire wr68 = e_fall && !WR_N_RW;
  wire par_rd = rd80 || rd68;
  wire par_wr = wr80 || wr68;
  wire rd_active = (mode80 && !RD_N_E) || (mode68 && RD_N_E && WR_N_RW);
  wire ser_rise = SERIAL_SEL && !SER_CS_N && SER_CLK && !sclk_q;
  wire ser_done = ser_rise && (ser_cnt_q == 3'h7);
  wire [7:0] ser_byte = {ser_sh_q, SER_DATA};

  // cycle classification; serial never yields a read
  lhcd_cycle_type cyc;
  assign cyc.op = lhcd_op_type'({REGISTER_SELECT, par_rd});
  assign cyc.data = ser_done ? ser_byte : DB_IN;
  wire cyc_valid = par_rd || par_wr || ser_done;
  wire busy = (state_q == S_INIT);

  // commands are dropped while initialisation runs
  wire is_cmd = cyc_valid && (cyc.op == OP_CMD) && !busy;
  wire dec_on = is_cmd && (cyc.data[7:1] == CMD_DISP_OFF[7:1]);
  wire dec_start = is_cmd && (cyc.data[7:6] == START_TOP);
  wire dec_page = is_cmd && (cyc.data[7:4] == PAGE_TOP) && (cyc.data[3:0] <= PAGE_MAX);
  wire dec_colh = is_cmd && (cyc.data[7:4] == COLH_TOP);
  wire dec_coll = is_cmd && (cyc.data[7:4] == COLL_TOP);
  wire dec_rst = is_cmd && (cyc.data == CMD_RESET);
  wire dec_any = dec_on || dec_start || dec_page || dec_colh || dec_coll || dec_rst;
  wire dat_wr = cyc_valid && (cyc.op == OP_WDAT) && !busy;
  wire dat_rd = cyc_valid && (cyc.op == OP_RDAT) && !busy;
  wire [11:0] host_addr = {page_q, col_q};

  wire [7:0] col_inc = (col_q == COL_MAX) ? col_q : col_q + 8'h01;
  // two-byte column load; advance on access
  always_comb begin
    col_d = col_q;
    if (dec_colh) begin
      col_d = {cyc.data[3:0], col_q[3:0]};
    end else if (dec_coll) begin
      col_d = {col_q[7:4], cyc.data[3:0]};
    end else if (dat_wr || dat_rd) begin
      col_d = col_inc;
    end
  end

  // status byte; direction fixed normal; off bit; reset bit
  wire [7:0] status = {busy, ADC_NORMAL, !disp_on_q, busy, 4'h0};

  always_ff @(posedge REF_CLK) begin
    rd_q <= RD_N_E;
    wr_q <= WR_N_RW;
    sclk_q <= SER_CLK;
  end

  // shift register clears whenever chip select drops away
  always_ff @(posedge REF_CLK) begin
    if (RST || SER_CS_N || !EXTERNAL_INIT_PIN_N) begin
      ser_cnt_q <= 3'h0;
      ser_sh_q <= 7'h00;
    end else if (ser_rise) begin
      ser_cnt_q <= ser_cnt_q + 3'h1;
      ser_sh_q <= {ser_sh_q[5:0], SER_DATA};
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST || !EXTERNAL_INIT_PIN_N) begin
      state_q <= S_INIT;
      cnt_q <= 16'(RESET_CYCLES - 1);
      disp_on_q <= 1'b0;
      start_q <= START_RST;
      page_q <= PAGE_RST;
      col_q <= COL_RST;
    end else begin
      unique case (state_q)
        S_INIT: begin
          if (cnt_q == 16'h0000) begin
            state_q <= S_RUN;
          end else begin
            cnt_q <= cnt_q - 16'h0001;
          end
        end
        S_RUN: begin
          if (dec_rst) begin
            // reset command keeps display on/off state
            state_q <= S_INIT;
            cnt_q <= 16'(RESET_CYCLES - 1);
          end
        end
      endcase
      if (dec_on) begin
        disp_on_q <= cyc.data[0];
      end
      if (dec_start || dec_rst) begin
        start_q <= dec_rst ? START_RST : cyc.data[5:0];
      end
      // page load; pages above 8 ignored
      if (dec_page || dec_rst) begin
        page_q <= dec_rst ? PAGE_RST : cyc.data[3:0];
      end
      col_q <= dec_rst ? COL_RST : col_d;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (dat_wr && EXTERNAL_INIT_PIN_N && !RST) begin
      ram_q[host_addr] <= cyc.data;
    end
  end

  // the latch is refilled after it is read, so the first read is stale
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      rd_latch_q <= 8'h00;
      dout_q <= 8'h00;
    end else begin
      if (dat_rd) begin
        rd_latch_q <= ram_q[host_addr];
      end
      dout_q <= REGISTER_SELECT ? rd_latch_q : status;
    end
  end

  assign DB_OUT = dout_q;
  assign DB_OE = rd_active;

  // scan 65 lines from start line, wrapping modulo 65
  wire [6:0] line_sum = {1'b0, start_q} + scan_cnt_q;
  wire [6:0] scan_line = (line_sum >= 7'(NUM_LINES)) ? line_sum - 7'(NUM_LINES) : line_sum;
  wire [11:0] scan_addr = {scan_line[6:3], scan_col_q};

  // scan uses its own address path, independent of the host page
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      scan_col_q <= 8'h00;
      scan_cnt_q <= 7'h00;
      scan_col_out_q <= 8'h00;
      col_drv_q <= 1'b1;
      row_drv_q <= '1;
    end else begin
      scan_col_q <= scan_col_q + 8'h01;
      if (scan_col_q == COL_MAX) begin
        scan_cnt_q <= (scan_cnt_q == 7'(NUM_LINES - 1)) ? 7'h00 : scan_cnt_q + 7'h01;
      end
      scan_col_out_q <= scan_col_q;
      col_drv_q <= !disp_on_q || ram_q[scan_addr][scan_line[2:0]];
      row_drv_q <= disp_on_q ? (NUM_LINES'(1) << scan_cnt_q) : '1;
    end
  end

  assign DISPLAY_ON = disp_on_q;
  assign COLUMN_DRIVER_OUTPUT = col_drv_q;
  assign ROW_DRIVER_OUTPUT = row_drv_q;
  assign SCAN_COLUMN = scan_col_out_q;

  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);

  chk_on_cmd: assert property (dec_on && EXTERNAL_INIT_PIN_N |=> disp_on_q == $past(cyc.data[0]))
    else $error("display on/off not taken");
  chk_off_drivers: assert property (!disp_on_q && EXTERNAL_INIT_PIN_N |=> COLUMN_DRIVER_OUTPUT && (&ROW_DRIVER_OUTPUT))
    else $error("drivers not high while off");
  chk_start_load: assert property (dec_start && EXTERNAL_INIT_PIN_N |=> start_q == $past(cyc.data[5:0]))
    else $error("start line not loaded");
  chk_colh_load: assert property (dec_colh && EXTERNAL_INIT_PIN_N |=> col_q[7:4] == $past(cyc.data[3:0]))
    else $error("column high nibble not loaded");
  chk_col_advance: assert property ((dat_wr || dat_rd) && col_q != COL_MAX && EXTERNAL_INIT_PIN_N
    |=> col_q == $past(col_q) + 8'h01)
    else $error("column did not advance");
  chk_col_saturate: assert property ((dat_wr || dat_rd) && col_q == COL_MAX && EXTERNAL_INIT_PIN_N
    |=> col_q == COL_MAX && page_q == $past(page_q))
    else $error("column saturation broken");
  chk_status_word: assert property (rd_active && !REGISTER_SELECT |=> DB_OUT[3:0] == 4'h0
    && DB_OUT[ST_OFF] == !$past(disp_on_q) && DB_OUT[ST_ADC])
    else $error("status byte wrong");
  chk_reset_busy: assert property (dec_rst && EXTERNAL_INIT_PIN_N |=> busy [*2])
    else $error("reset command not busy");
  chk_pin_init: assert property (!EXTERNAL_INIT_PIN_N |=> !disp_on_q && col_q == 8'h00 && page_q == 4'h0
    && start_q == 6'h00 && busy)
    else $error("init pin did not initialise");
  chk_ignore_cmd: assert property (is_cmd && !dec_any && EXTERNAL_INIT_PIN_N |=> $stable(col_q)
    && $stable(page_q) && $stable(start_q) && $stable(disp_on_q))
    else $error("undefined command changed state");

  chk_coll_load: assert property (dec_coll && EXTERNAL_INIT_PIN_N |=> col_q[3:0] == $past(cyc.data[3:0]))
    else $error("column low nibble not loaded");
  chk_page_load: assert property (dec_page && EXTERNAL_INIT_PIN_N |=> page_q == $past(cyc.data[3:0]))
    else $error("page not loaded");
  chk_page_refuse: assert property (is_cmd && cyc.data[7:4] == PAGE_TOP && cyc.data[3:0] > PAGE_MAX
    && EXTERNAL_INIT_PIN_N |=> $stable(page_q))
    else $error("page above range taken");
  chk_page_range: assert property (page_q <= PAGE_MAX)
    else $error("page out of range");
  chk_page_display: assert property (dec_page && EXTERNAL_INIT_PIN_N |=> $stable(start_q) && $stable(disp_on_q))
    else $error("page change altered display");
  chk_row_onehot: assert property (disp_on_q |=> $onehot(ROW_DRIVER_OUTPUT))
    else $error("row drive not one-hot");
  chk_scan_wrap: assert property (scan_cnt_q <= 7'(NUM_LINES - 1))
    else $error("scan row count past last line");
  chk_line_range: assert property (scan_line < 7'(NUM_LINES))
    else $error("scanned line out of range");
  chk_ser_count: assert property (SER_CS_N |=> ser_cnt_q == 3'h0)
    else $error("serial bit count not cleared");
  chk_serial_noread: assert property (SERIAL_SEL |-> !dat_rd && !DB_OE)
    else $error("read while serial port selected");
  chk_busy_bits: assert property (rd_active && !REGISTER_SELECT |=> DB_OUT[ST_BUSY] == $past(busy)
    && DB_OUT[ST_RST] == $past(busy))
    else $error("busy or reset status bit wrong");
  chk_read_data: assert property (rd_active && REGISTER_SELECT |=> DB_OUT == $past(rd_latch_q))
    else $error("read data not from latch");
  chk_busy_ignore: assert property (busy && cyc_valid && EXTERNAL_INIT_PIN_N |=> $stable(col_q)
    && $stable(page_q) && $stable(start_q) && $stable(disp_on_q))
    else $error("access taken while busy");
  chk_rstcmd_clear: assert property (dec_rst && EXTERNAL_INIT_PIN_N |=> col_q == COL_RST && page_q == PAGE_RST
    && start_q == START_RST && disp_on_q == $past(disp_on_q))
    else $error("reset command state wrong");
  chk_busy_hold: assert property (busy && cnt_q != 16'h0000 && EXTERNAL_INIT_PIN_N |=> busy)
    else $error("busy ended early");
  chk_busy_count: assert property (busy |-> cnt_q < 16'(RESET_CYCLES))
    else $error("init counter out of range");
endmodule

// file: rtl/lhcd_pkg.sv
// constants and types for the lcd host command decoder
package lhcd_pkg;
  localparam int COL_W = 8;
  localparam int PAGE_W = 4;
  localparam int LINE_W = 6;
  localparam int NUM_LINES = 65;
  localparam int RAM_WORDS = 9 * 256;
  localparam logic [3:0] PAGE_MAX = 4'h8;
  localparam logic [7:0] COL_MAX = 8'hff;
  localparam logic [7:0] CMD_DISP_OFF = 8'hae;
  localparam logic [7:0] CMD_RESET = 8'he2;
  localparam logic [1:0] START_TOP = 2'h1;
  localparam logic [3:0] PAGE_TOP = 4'hb;
  localparam logic [3:0] COLH_TOP = 4'h1;
  localparam logic [3:0] COLL_TOP = 4'h0;
  localparam int ST_BUSY = 7;
  localparam int ST_ADC = 6;
  localparam int ST_OFF = 5;
  localparam int ST_RST = 4;
  localparam logic ADC_NORMAL = 1'b1;
  localparam logic [7:0] COL_RST = 8'h00;
  localparam logic [3:0] PAGE_RST = 4'h0;
  localparam logic [5:0] START_RST = 6'h00;
  localparam int CLK_NS = 100;
  localparam int RESET_NS = 1000;
  localparam int RESET_CYC = (RESET_NS + CLK_NS - 1) / CLK_NS;
  typedef enum logic [1:0] {
    OP_CMD = 2'b00,
    OP_STAT = 2'b01,
    OP_WDAT = 2'b10,
    OP_RDAT = 2'b11
  } lhcd_op_type;
  typedef struct packed {
    lhcd_op_type op;
    logic [7:0] data;
  } lhcd_cycle_type;
  typedef enum logic {
    S_RUN = 1'b0,
    S_INIT = 1'b1
  } lhcd_state_type;
endpackage

// file: sim/lhcd_host.sv
// host processor model for the parallel and serial ports
`timescale 1ns/1ps
module lhcd_host (
  // clock and read-back
  input wire logic clk,
  input wire logic [7:0] db_out,
  // bus drive
  output logic rs,
  output logic rd_n_e,
  output logic wr_n_rw,
  output logic [7:0] db_in,
  output logic ser_cs_n,
  output logic ser_clk,
  output logic ser_data,
  output logic serial_sel,
  output logic bus68_sel
);
  initial begin
    {rs, rd_n_e, wr_n_rw, ser_cs_n, ser_clk, ser_data, serial_sel, bus68_sel} = 8'h70;
    db_in = 8'h00;
  end
  task automatic set_mode(input logic s, input logic m);
    // strobe moves to the new idle level first so neither mode sees a false edge
    @(posedge clk) #1;
    rd_n_e = ~m;
    wr_n_rw = 1'b1;
    @(posedge clk) #1;
    serial_sel = s;
    bus68_sel = m;
  endtask
  // strobe whole cycles, data held past its end, an idle cycle after
  task automatic xfer(input logic a, input logic rd, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk) #1;
    rs = a;
    db_in = d;
    if (bus68_sel) begin
      wr_n_rw = rd;
      rd_n_e = 1'b1;
    end else if (rd) rd_n_e = 1'b0;
    else wr_n_rw = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    q = db_out;
    rd_n_e = ~bus68_sel;
    // direction stands through the enable fall that takes the write
    if (!bus68_sel) wr_n_rw = 1'b1;
    @(posedge clk) #1;
    wr_n_rw = 1'b1;
    // released bus shows the inverse so a stale byte cannot pass
    db_in = ~d;
  endtask
  // msb first; clock stands low outside a frame
  task automatic ser(input logic a, input logic [7:0] d);
    @(posedge clk) #1;
    ser_cs_n = 1'b0;
    rs = a;
    for (int i = 7; i >= 0; i--) begin
      ser_data = d[i];
      ser_clk = 1'b0;
      @(posedge clk) #1;
      ser_clk = 1'b1;
      @(posedge clk) #1;
    end
    ser_clk = 1'b0;
    ser_cs_n = 1'b1;
    ser_data = ~d[0];
  endtask
endmodule

// file: sim/tb_top.sv
// self-checking bench for the lcd host command decoder
`timescale 1ns/1ps
module tb_top import lhcd_pkg::*;;
  localparam int RC = 8;
  logic clk = 1'b0, rst = 1'b1, init_n = 1'b1;
  logic rs, rd, wr, cs, sck, sda, ssel, m68, oe, disp_on, col_drv;
  logic [7:0] db_in, db_out, scol, q;
  logic [NUM_LINES-1:0] rows;
  int bad_count = 0, tests_run = 0;
  always #50 clk = ~clk;
  lhcd_decoder #(.RESET_CYCLES(RC)) i_lhcd_decoder (.REF_CLK(clk), .RST(rst), .EXTERNAL_INIT_PIN_N(init_n),
    .SERIAL_SEL(ssel), .BUS68_SEL(m68), .REGISTER_SELECT(rs), .RD_N_E(rd), .WR_N_RW(wr), .DB_IN(db_in),
    .DB_OUT(db_out), .DB_OE(oe), .SER_CS_N(cs), .SER_CLK(sck), .SER_DATA(sda), .DISPLAY_ON(disp_on),
    .COLUMN_DRIVER_OUTPUT(col_drv), .ROW_DRIVER_OUTPUT(rows), .SCAN_COLUMN(scol));
  lhcd_host i_lhcd_host (.clk(clk), .db_out(db_out), .rs(rs), .rd_n_e(rd), .wr_n_rw(wr), .db_in(db_in),
    .ser_cs_n(cs), .ser_clk(sck), .ser_data(sda), .serial_sel(ssel), .bus68_sel(m68));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] c);
    i_lhcd_host.xfer(1'b0, 1'b0, c, q);
  endtask
  task automatic wd(input logic [7:0] d);
    i_lhcd_host.xfer(1'b1, 1'b0, d, q);
  endtask
  task automatic rdd(input logic a);
    i_lhcd_host.xfer(a, 1'b1, 8'h00, q);
  endtask
  task automatic addr(input logic [3:0] p, input logic [7:0] c);
    cmd({PAGE_TOP, p});
    cmd({COLH_TOP, c[7:4]});
    cmd({COLL_TOP, c[3:0]});
  endtask
  task automatic t_init();
    @(posedge clk) #1 init_n = 1'b0;
    rdd(1'b0);
    chk(q, 8'hf0);
    chk({5'h0, disp_on, col_drv, &rows}, 8'h03);
    init_n = 1'b1;
    repeat (RC + 4) @(posedge clk);
    rdd(1'b0);
    chk(q, 8'h60);
    $display("test init done");
  endtask
  task automatic t_disp();
    cmd(8'haf);
    fork
      rdd(1'b0);
      begin
        repeat (2) @(posedge clk);
        #1 chk({7'h0, oe}, 8'h01);
      end
    join
    chk(q, 8'h40);
    chk({7'h0, oe}, 8'h00);
    chk({6'h0, disp_on, ($countones(rows) == 1)}, 8'h03);
    cmd(CMD_DISP_OFF);
    repeat (2) @(posedge clk);
    #1 chk({5'h0, disp_on, col_drv, &rows}, 8'h03);
    $display("test display done");
  endtask
  task automatic t_rw(input logic m);
    logic [7:0] pat [3] = '{8'ha5, 8'h5a, 8'h3c};
    i_lhcd_host.set_mode(1'b0, m);
    addr(4'h3, 8'h12);
    foreach (pat[i]) wd(pat[i] ^ {8{m}});
    addr(4'h3, 8'h12);
    rdd(1'b1);
    foreach (pat[i]) begin
      rdd(1'b1);
      chk(q, pat[i] ^ {8{m}});
    end
    $display("test access done");
  endtask
  task automatic t_sat();
    i_lhcd_host.set_mode(1'b0, 1'b0);
    addr(4'h3, COL_MAX);
    wd(8'h11);
    wd(8'h22);
    wd(8'h33);
    addr(4'h3, COL_MAX);
    rdd(1'b1);
    rdd(1'b1);
    chk(q, 8'h33);
    rdd(1'b1);
    chk(q, 8'h33);
    $display("test saturation done");
  endtask
  task automatic t_bad();
    addr(4'h3, 8'h20);
    wd(8'h77);
    cmd(8'hb9);
    cmd(8'h9c);
    cmd(8'h12);
    cmd(8'h00);
    rdd(1'b1);
    rdd(1'b1);
    chk(q, 8'h77);
    $display("test refused done");
  endtask
  task automatic t_ser();
    i_lhcd_host.set_mode(1'b1, 1'b0);
    i_lhcd_host.ser(1'b0, 8'hb5);
    i_lhcd_host.ser(1'b0, 8'h14);
    i_lhcd_host.ser(1'b0, 8'h00);
    i_lhcd_host.ser(1'b1, 8'hc3);
    i_lhcd_host.set_mode(1'b0, 1'b0);
    // page stays as the serial page command left it
    cmd({COLH_TOP, 4'h4});
    cmd({COLL_TOP, 4'h0});
    rdd(1'b1);
    rdd(1'b1);
    chk(q, 8'hc3);
    $display("test serial done");
  endtask
  task automatic t_rcmd();
    cmd(8'haf);
    addr(4'h2, 8'h55);
    cmd(CMD_RESET);
    rdd(1'b0);
    chk(q, 8'hd0);
    // no command until busy has ended
    repeat (RC + 4) @(posedge clk);
    rdd(1'b0);
    chk(q, 8'h40);
    wd(8'h99);
    addr(4'h0, 8'h00);
    rdd(1'b1);
    rdd(1'b1);
    chk(q, 8'h99);
    $display("test reset command done");
  endtask
  task automatic t_scan();
    logic [7:0] pix [9] = '{8'h5a, 8'h96, 8'h0f, 8'hc3, 8'h69, 8'ha5, 8'h3c, 8'hf0, 8'h81};
    int r;
    int ln;
    cmd(8'haf);
    for (int p = 0; p < 9; p++) begin
      addr(4'(p), 8'h80);
      wd(pix[p]);
    end
    cmd({START_TOP, 6'h2d});
    // a host page change must leave the picture alone
    cmd({PAGE_TOP, 4'h6});
    repeat (3) begin
      @(posedge clk) #1;
      while (scol !== 8'h80) begin
        @(posedge clk) #1;
      end
      r = 0;
      for (int i = 0; i < NUM_LINES; i++) begin
        if (rows[i]) r = i;
      end
      ln = (45 + r) % NUM_LINES;
      chk({7'h0, col_drv}, {7'h0, pix[ln / 8][ln % 8]});
    end
    $display("test scan done");
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    complete_run();
  end
  initial begin
    repeat (16) @(posedge clk);
    #1 rst = 1'b0;
    t_init();
    t_disp();
    t_rw(1'b0);
    t_rw(1'b1);
    t_sat();
    t_bad();
    t_ser();
    t_rcmd();
    t_scan();
    complete_run();
  end
endmodule
